// ### src/file_reg_ram.sv
// Byte-wide file register array with one write port and a registered read port.
// Assumes read address and write controls come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module file_reg_ram (
  input wire logic mclk_i, // Core clock.
  input wire logic we_i, // Write strobe.
  input wire logic [incdec_exec_pkg::ADDR_W-1:0] waddr_i, // Write address.
  input wire logic [incdec_exec_pkg::DATA_W-1:0] wdata_i, // Write data.
  input wire logic [incdec_exec_pkg::ADDR_W-1:0] raddr_i, // Read address.
  output logic [incdec_exec_pkg::DATA_W-1:0] rdata_o // Read data, one cycle late.
);
  import incdec_exec_pkg::*;

  logic [DATA_W-1:0] mem [FILE_DEPTH];

  // Read data comes from a register, so the read sees the old byte on a collision.
  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule : file_reg_ram

`default_nettype wire

// ### src/incdec_exec_pkg.sv
// Constants and types shared by the increment/decrement/OR/jump execution block.
// Assumes a single core clock and a file register array of 128 bytes.

package incdec_exec_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int LIT_W = 11;
  localparam int PC_W = 13;
  localparam int LATCH_W = 5;
  localparam int LATCH_HI = 4;
  localparam int LATCH_LO = 3;
  localparam int FILE_DEPTH = 128;

  localparam logic [DATA_W-1:0] ONE = 8'h01;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
  localparam logic [PC_W-1:0] PC_SKIP_STEP = 13'h0002;

  // Operation codes presented on the instruction port.
  localparam logic [2:0] OP_NOP = 3'h0;
  localparam logic [2:0] OP_DEC_SKIP = 3'h1;
  localparam logic [2:0] OP_INC_SKIP = 3'h2;
  localparam logic [2:0] OP_INC = 3'h3;
  localparam logic [2:0] OP_OR_IMM = 3'h4;
  localparam logic [2:0] OP_OR_REG = 3'h5;
  localparam logic [2:0] OP_JUMP = 3'h6;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_SKIP = 4'b0100,
    ST_FLUSH = 4'b1000
  } exec_state_t;

endpackage : incdec_exec_pkg

// ### src/incdec_skip_or_jump_exec.sv
// Execution unit for decrement-skip, increment-skip, increment, the two OR forms
// and the absolute jump, with its own file register array, accumulator, zero flag
// and program counter. Assumes one instruction is offered at a time with a
// valid/ready handshake, all from logic on the core clock.
`timescale 1ns/1ps
`default_nettype none

module incdec_skip_or_jump_exec (
  input wire logic mclk_i, // Core clock, 200 MHz.
  input wire logic rst_n_i, // Synchronous reset, active low.
  input wire logic instr_valid_i, // Instruction offered.
  input wire logic [2:0] instr_op_i, // Operation code.
  input wire logic [incdec_exec_pkg::ADDR_W-1:0] instr_addr_i, // File register address.
  input wire logic instr_dest_i, // Destination select.
  input wire logic [incdec_exec_pkg::LIT_W-1:0] instr_lit_i, // Literal or jump target.
  input wire logic [incdec_exec_pkg::LATCH_W-1:0] pc_upper_latch_i, // Upper pc latch.
  input wire logic preload_file_i, // Load a file register while idle.
  input wire logic preload_acc_i, // Load the accumulator while idle.
  input wire logic [incdec_exec_pkg::DATA_W-1:0] preload_data_i, // Preload data.
  output logic instr_ready_o, // Ready to take an instruction.
  output logic [incdec_exec_pkg::DATA_W-1:0] acc_o, // Accumulator.
  output logic zero_o, // Zero flag.
  output logic [incdec_exec_pkg::PC_W-1:0] pc_o, // Program counter.
  output logic skip_o, // Pulse during the inserted no-op.
  output logic done_o // Pulse when an instruction completes.
);
  import incdec_exec_pkg::*;

  typedef struct packed {
    exec_state_t st;
    logic [2:0] op;
    logic [ADDR_W-1:0] addr;
    logic dest;
    logic [LIT_W-1:0] lit;
    logic [1:0] hi;
    logic [DATA_W-1:0] acc;
    logic zero;
    logic [PC_W-1:0] pc;
    logic ready;
    logic skip;
    logic done;
  } exec_regs_t;

  exec_regs_t s;
  exec_regs_t next_s;

  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] result;
  logic mem_we;
  logic [ADDR_W-1:0] mem_waddr;
  logic [DATA_W-1:0] mem_wdata;
  logic [ADDR_W-1:0] mem_raddr;

  // Operations that carry a destination select bit.
  function automatic logic has_dest(input logic [2:0] op);
    has_dest = (op == OP_DEC_SKIP) || (op == OP_INC_SKIP) ||
               (op == OP_INC) || (op == OP_OR_REG);
  endfunction : has_dest

  // Operations that end in a skip test on their result.
  function automatic logic is_skip_op(input logic [2:0] op);
    is_skip_op = (op == OP_DEC_SKIP) || (op == OP_INC_SKIP);
  endfunction : is_skip_op

  // Operations that update the zero flag.
  function automatic logic sets_zero(input logic [2:0] op);
    sets_zero = (op == OP_INC) || (op == OP_OR_IMM) || (op == OP_OR_REG);
  endfunction : sets_zero

  wire accept = s.ready && instr_valid_i;
  wire exec = (s.st == ST_EXEC);

  file_reg_ram u_file (
    .mclk_i(mclk_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_i(mem_raddr),
    .rdata_o(rd_data)
  );

  // The read is launched on the accept edge so the operand is ready in the
  // execute cycle; this costs no extra state for the file register fetch.
  assign mem_raddr = instr_addr_i;

  // Arithmetic and logic; the 8-bit width gives the modulo-256 wrap for free.
  always_comb begin
    case (s.op)
      OP_DEC_SKIP: result = rd_data - ONE;
      OP_INC_SKIP: result = rd_data + ONE;
      OP_INC: result = rd_data + ONE;
      OP_OR_IMM: result = s.acc | s.lit[DATA_W-1:0];
      OP_OR_REG: result = s.acc | rd_data;
      default: result = ACC_RESET;
    endcase
  end

  // File write port: result write-back in execute, or a preload while idle.
  always_comb begin
    mem_we = 1'b0;
    mem_waddr = s.addr;
    mem_wdata = result;
    if (exec && has_dest(s.op) && s.dest) begin
      mem_we = 1'b1;
    end else if (s.ready && !instr_valid_i && preload_file_i) begin
      mem_we = 1'b1;
      mem_waddr = instr_addr_i;
      mem_wdata = preload_data_i;
    end
  end

  // Sequencer: idle, execute, then an optional no-op or jump flush cycle.
  always_comb begin
    next_s = s;
    next_s.skip = 1'b0;
    next_s.done = 1'b0;
    case (s.st)
      ST_IDLE: begin
        if (accept) begin
          next_s.st = ST_EXEC;
          next_s.ready = 1'b0;
          next_s.op = instr_op_i;
          next_s.addr = instr_addr_i;
          next_s.dest = instr_dest_i;
          next_s.lit = instr_lit_i;
          next_s.hi = pc_upper_latch_i[LATCH_HI:LATCH_LO];
        end else if (preload_acc_i) begin
          next_s.acc = preload_data_i;
        end
      end
      ST_EXEC: begin
        // Accumulator write when the destination select is clear, and always for OP_OR_IMM.
        if ((has_dest(s.op) && !s.dest) || s.op == OP_OR_IMM) begin
          next_s.acc = result;
        end
        // Only INC and the OR forms touch the flag; skips and jump keep it.
        if (sets_zero(s.op)) begin
          next_s.zero = (result == ACC_RESET);
        end
        if (s.op == OP_JUMP) begin
          next_s.pc = {s.hi, s.lit};
          next_s.st = ST_FLUSH;
        end else if (is_skip_op(s.op) && result == ACC_RESET) begin
          next_s.pc = s.pc + PC_SKIP_STEP;
          next_s.st = ST_SKIP;
          next_s.skip = 1'b1;
        end else begin
          next_s.pc = s.pc + PC_STEP;
          next_s.st = ST_IDLE;
          next_s.ready = 1'b1;
          next_s.done = 1'b1;
        end
      end
      ST_SKIP: begin
        // The discarded instruction's slot runs as a no-op.
        next_s.st = ST_IDLE;
        next_s.ready = 1'b1;
        next_s.done = 1'b1;
      end
      ST_FLUSH: begin
        // Second jump cycle refills the fetch path; nothing else changes.
        next_s.st = ST_IDLE;
        next_s.ready = 1'b1;
        next_s.done = 1'b1;
      end
      default: begin
        next_s.st = ST_IDLE;
        next_s.ready = 1'b1;
      end
    endcase
  end

  // State register; reset clears every field except the state, which goes to ST_IDLE, and ready, which is set to open the instruction port.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.acc <= ACC_RESET;
      s.pc <= PC_RESET;
      s.ready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign instr_ready_o = s.ready;
  assign acc_o = s.acc;
  assign zero_o = s.zero;
  assign pc_o = s.pc;
  assign skip_o = s.skip;
  assign done_o = s.done;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_dest_acc_write: assert property (
    (exec && has_dest(s.op) && !s.dest) |=> (acc_o == $past(result)))
    else $error("Accumulator did not take the result.");

  a_dest_file_keep: assert property (
    (exec && has_dest(s.op) && s.dest) |=> $stable(acc_o))
    else $error("Accumulator changed on a file destination.");

  a_dec_skip_zero: assert property (
    (exec && s.op == OP_DEC_SKIP && rd_data == ONE)
      |=> skip_o ##1 (done_o && instr_ready_o))
    else $error("Decrement to zero did not insert one no-op.");

  a_no_skip_nonzero: assert property (
    (exec && is_skip_op(s.op) && result != ACC_RESET) |=> (!skip_o && done_o))
    else $error("Skip inserted on a non-zero result.");

  a_skip_flags_kept: assert property (
    (exec && (is_skip_op(s.op) || s.op == OP_JUMP)) |=> $stable(zero_o))
    else $error("Zero flag changed on a flag-neutral instruction.");

  a_inc_skip_wrap: assert property (
    (exec && s.op == OP_INC_SKIP && rd_data == 8'hFF)
      |=> (skip_o && pc_o == $past(pc_o) + PC_SKIP_STEP))
    else $error("Increment skip at 0xFF did not skip.");

  a_jump_pc_load: assert property (
    (exec && s.op == OP_JUMP) |=> (pc_o[LIT_W-1:0] == $past(s.lit)))
    else $error("Jump target low bits wrong.");

  a_jump_upper_bits: assert property (
    (accept && instr_op_i == OP_JUMP)
      |=> ##1 (pc_o[PC_W-1:LIT_W] == $past(pc_upper_latch_i[LATCH_HI:LATCH_LO], 2)))
    else $error("Jump upper bits not from the latch.");

  a_jump_two_cycles: assert property (
    (exec && s.op == OP_JUMP) |=> (!done_o && !instr_ready_o) ##1 done_o)
    else $error("Jump did not take two cycles.");

  a_zero_flag_set: assert property (
    (exec && sets_zero(s.op)) |=> (zero_o == ($past(result) == ACC_RESET)))
    else $error("Zero flag does not match the result.");

  a_inc_never_skip: assert property (
    (exec && s.op == OP_INC) |=> (!skip_o && pc_o == $past(pc_o) + PC_STEP))
    else $error("Plain increment skipped.");

  a_dec_wrap: assert property (
    (exec && s.op == OP_DEC_SKIP && rd_data == ACC_RESET) |-> (result == 8'hFF))
    else $error("Decrement of zero did not wrap.");

  // Datapath checks: each result lands where the destination select sends it, and the
  // inserted no-op and the jump flush cycle leave the architectural state alone.
  a_acc_dest_nowrite: assert property (
    (exec && has_dest(s.op) && !s.dest)
      |-> !mem_we)
    else $error("File written on an accumulator destination.");

  a_file_dest_write: assert property (
    (exec && has_dest(s.op) && s.dest)
      |-> (mem_we && mem_waddr == s.addr && mem_wdata == result))
    else $error("File register did not take the result.");

  a_dec_file_value: assert property (
    (exec && s.op == OP_DEC_SKIP && s.dest)
      |-> (mem_wdata == rd_data - ONE))
    else $error("Decrement wrote a wrong value to the file.");

  a_inc_acc_value: assert property (
    (exec && s.op == OP_INC && !s.dest)
      |=> (acc_o == $past(rd_data) + ONE))
    else $error("Increment gave a wrong accumulator value.");

  a_inc_skip_value: assert property (
    (exec && s.op == OP_INC_SKIP && !s.dest)
      |=> (acc_o == $past(rd_data) + ONE))
    else $error("Increment skip gave a wrong accumulator value.");

  a_or_imm_value: assert property (
    (exec && s.op == OP_OR_IMM)
      |=> (acc_o == ($past(acc_o) | $past(s.lit[DATA_W-1:0]))))
    else $error("OR with literal gave a wrong value.");

  a_or_reg_value: assert property (
    (exec && s.op == OP_OR_REG && !s.dest)
      |=> (acc_o == ($past(acc_o) | $past(rd_data))))
    else $error("OR with register gave a wrong value.");

  a_skip_only_zero: assert property (
    skip_o
      |-> ($past(result) == ACC_RESET))
    else $error("No-op inserted after a non-zero result.");

  a_skip_noop_quiet: assert property (
    skip_o
      |=> ($stable(acc_o) && $stable(zero_o) && $stable(pc_o)))
    else $error("Inserted no-op changed the state.");

  a_skip_then_done: assert property (
    skip_o
      |=> (done_o && instr_ready_o && !skip_o))
    else $error("Inserted no-op lasted more than one cycle.");

  a_jump_flush_quiet: assert property (
    (exec && s.op == OP_JUMP)
      |=> $stable(acc_o) ##1 ($stable(pc_o) && $stable(zero_o)))
    else $error("Jump changed the accumulator or flag.");

  a_jump_no_file: assert property (
    (exec && s.op == OP_JUMP)
      |-> !mem_we)
    else $error("Jump wrote the file register array.");

  a_zero_flag_clear: assert property (
    (exec && sets_zero(s.op) && result != ACC_RESET)
      |=> !zero_o)
    else $error("Zero flag set on a non-zero result.");

endmodule : incdec_skip_or_jump_exec

`default_nettype wire

// ### verification/incdec_skip_or_jump_exec_tb.sv
// Self-checking bench for the increment/decrement/OR/jump execution unit.
// Assumes the unit's package is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none

module incdec_skip_or_jump_exec_tb;
  import incdec_exec_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic instr_valid_i = 1'b0;
  logic [2:0] instr_op_i = 3'h0;
  logic [ADDR_W-1:0] instr_addr_i = '0;
  logic instr_dest_i = 1'b0;
  logic [LIT_W-1:0] instr_lit_i = '0;
  logic [LATCH_W-1:0] pc_upper_latch_i = '0;
  logic preload_file_i = 1'b0;
  logic preload_acc_i = 1'b0;
  logic [DATA_W-1:0] preload_data_i = '0;
  logic instr_ready_o;
  logic zero_o;
  logic skip_o;
  logic done_o;
  logic [DATA_W-1:0] acc_o;
  logic [PC_W-1:0] pc_o;
  logic [PC_W-1:0] exp_pc = '0;
  int num_errors = 0;
  int comparisons = 0;

  // A 5 ns period gives the 200 MHz core clock.
  always #2.5 mclk_i = ~mclk_i;

  incdec_skip_or_jump_exec u_incdec_skip_or_jump_exec (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
    .instr_op_i(instr_op_i), .instr_addr_i(instr_addr_i), .instr_dest_i(instr_dest_i),
    .instr_lit_i(instr_lit_i), .pc_upper_latch_i(pc_upper_latch_i),
    .preload_file_i(preload_file_i), .preload_acc_i(preload_acc_i),
    .preload_data_i(preload_data_i), .instr_ready_o(instr_ready_o), .acc_o(acc_o),
    .zero_o(zero_o), .pc_o(pc_o), .skip_o(skip_o), .done_o(done_o)
  );

  // Compares with case equality so an unknown never passes.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // Preloads the accumulator or one file byte; the strobe stays up for exactly one edge.
  task automatic load(input logic to_acc, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
    @(posedge mclk_i);
    instr_addr_i <= a;
    preload_data_i <= d;
    preload_acc_i <= to_acc;
    preload_file_i <= ~to_acc;
    @(posedge mclk_i);
    preload_acc_i <= 1'b0;
    preload_file_i <= 1'b0;
  endtask : load

  // Offers one instruction, counts edges from accept to done and judges skip and pc.
  task automatic issue(input logic [2:0] op, input logic [ADDR_W-1:0] a, input logic d,
                       input logic [LIT_W-1:0] lit, input logic [LATCH_W-1:0] lat,
                       input logic exp_skip);
    int cyc;
    logic sk;
    logic long_op;
    cyc = 0;
    sk = 1'b0;
    long_op = exp_skip || (op == OP_JUMP);
    @(posedge mclk_i);
    instr_valid_i <= 1'b1;
    instr_op_i <= op;
    instr_addr_i <= a;
    instr_dest_i <= d;
    instr_lit_i <= lit;
    pc_upper_latch_i <= lat;
    @(posedge mclk_i);
    instr_valid_i <= 1'b0;
    // Bounded wait; a missing done shows up as a wrong cycle count.
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk_i);
      #1;
      cyc++;
      if (skip_o === 1'b1) sk = 1'b1;
      if (done_o === 1'b1) break;
    end
    if (op == OP_JUMP) exp_pc = {lat[LATCH_HI:LATCH_LO], lit};
    else exp_pc = exp_pc + (exp_skip ? PC_SKIP_STEP : PC_STEP);
    check(16'(cyc), long_op ? 16'h0002 : 16'h0001, "cycles");
    check(16'(sk), 16'(exp_skip), "skip");
    check(16'(pc_o), 16'(exp_pc), "pc");
  endtask : issue

  task automatic t_reset;
    check(16'(acc_o), 16'(ACC_RESET), "reset acc");
    check(16'(zero_o), 16'h0000, "reset zero");
    check(16'(pc_o), 16'(PC_RESET), "reset pc");
    check(16'(instr_ready_o), 16'h0001, "reset ready");
  endtask : t_reset

  // Decrement-skip: 2 to 1 (no skip), 1 to 0 (skip), then 0 wraps into the accumulator.
  task automatic t_dec_skip;
    load(1'b0, 7'h05, 8'h02);
    issue(OP_DEC_SKIP, 7'h05, 1'b1, '0, '0, 1'b0);
    check(16'(acc_o), 16'h0000, "dec acc kept");
    issue(OP_DEC_SKIP, 7'h05, 1'b1, '0, '0, 1'b1);
    check(16'(zero_o), 16'h0000, "dec zero kept");
    issue(OP_DEC_SKIP, 7'h05, 1'b0, '0, '0, 1'b0);
    check(16'(acc_o), 16'h00ff, "dec wrap");
    issue(OP_INC, 7'h05, 1'b0, '0, '0, 1'b0);
    check(16'(acc_o), 16'h0001, "file kept");
  endtask : t_dec_skip

  // Increment-skip with the zero flag set beforehand, so a flag write would show.
  task automatic t_inc_skip;
    load(1'b1, '0, 8'h00);
    issue(OP_OR_IMM, '0, 1'b0, 11'h000, '0, 1'b0);
    check(16'(zero_o), 16'h0001, "or zero set");
    load(1'b0, 7'h09, 8'hff);
    issue(OP_INC_SKIP, 7'h09, 1'b0, '0, '0, 1'b1);
    check(16'(acc_o), 16'h0000, "incskip acc");
    check(16'(zero_o), 16'h0001, "incskip zero kept");
    load(1'b1, '0, 8'h5a);
    issue(OP_INC_SKIP, 7'h09, 1'b1, '0, '0, 1'b1);
    check(16'(acc_o), 16'h005a, "incskip to file");
    issue(OP_INC_SKIP, 7'h09, 1'b0, '0, '0, 1'b0);
    check(16'(acc_o), 16'h0001, "incskip nonzero");
    check(16'(zero_o), 16'h0001, "incskip nonzero zero kept");
    load(1'b0, 7'h0a, 8'hff);
    issue(OP_INC, 7'h0a, 1'b1, '0, '0, 1'b0);
    check(16'(zero_o), 16'h0001, "inc zero set");
    check(16'(acc_o), 16'h0001, "inc acc kept");
    issue(OP_INC, 7'h0a, 1'b0, '0, '0, 1'b0);
    check(16'(acc_o), 16'h0001, "inc to acc");
    check(16'(zero_o), 16'h0000, "inc zero clear");
  endtask : t_inc_skip

  // Both OR forms; the literal's upper three bits must be ignored.
  task automatic t_or;
    load(1'b1, '0, 8'h50);
    issue(OP_OR_IMM, '0, 1'b0, 11'h7a5, '0, 1'b0);
    check(16'(acc_o), 16'h00f5, "or imm");
    load(1'b1, '0, 8'h30);
    load(1'b0, 7'h03, 8'h0c);
    issue(OP_OR_REG, 7'h03, 1'b1, '0, '0, 1'b0);
    check(16'(acc_o), 16'h0030, "or reg to file");
    check(16'(zero_o), 16'h0000, "or reg zero");
    issue(OP_INC, 7'h03, 1'b0, '0, '0, 1'b0);
    check(16'(acc_o), 16'h003d, "or reg stored");
    load(1'b1, '0, 8'h00);
    load(1'b0, 7'h04, 8'h00);
    issue(OP_OR_REG, 7'h04, 1'b0, '0, '0, 1'b0);
    check(16'(acc_o), 16'h0000, "or reg acc");
    check(16'(zero_o), 16'h0001, "or reg zero set");
  endtask : t_or

  // Jumps at both ends of the target range with different latch bits. The accumulator
  // is made non-zero and the flag clear first, so a stray write of a zero result shows.
  task automatic t_jump;
    issue(OP_OR_IMM, '0, 1'b0, 11'h001, '0, 1'b0);
    issue(OP_JUMP, '0, 1'b0, 11'h7ff, 5'h16, 1'b0);
    check(16'(zero_o), 16'h0000, "jump zero kept");
    issue(OP_JUMP, '0, 1'b0, 11'h000, 5'h0f, 1'b0);
    check(16'(acc_o), 16'h0001, "jump acc kept");
    issue(OP_NOP, '0, 1'b0, '0, '0, 1'b0);
    check(16'(acc_o), 16'h0001, "nop acc kept");
  endtask : t_jump

  // Main sequence: 20 cycles of reset, then each scenario in turn.
  initial begin
    repeat (20) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    #1;
    t_reset();
    t_dec_skip();
    t_inc_skip();
    t_or();
    t_jump();
    end_of_test();
  end

  // The whole run needs about a hundred cycles; this limit leaves a wide margin.
  initial begin
    repeat (3000) @(posedge mclk_i);
    num_errors++;
    end_of_test();
  end
endmodule : incdec_skip_or_jump_exec_tb
`default_nettype wire
